// ===== hw/mrn_responder.sv
`timescale 1ns/10ps
// Serial request responder for the node status and measurement map.
module mrn_responder import mrn_pkg::*; (
  // Clock and reset.
  input  wire logic                  REF_CLK_I,
  input  wire logic                  NRST_I,
  // Configuration.
  input  wire logic [7:0]            SLAVE_ADDR_I,
  // Received bytes and the end-of-frame gap.
  input  wire logic [7:0]            RX_DATA_I,
  input  wire logic                  RX_VALID_I,
  input  wire logic                  RX_END_I,
  // Node values.
  output logic      [8:0]            IREG_IDX_O,
  input  wire logic [15:0]           IREG_DATA_I,
  input  wire logic [COIL_TOTAL-1:0] COIL_I,
  input  wire logic [DISC_TOTAL-1:0] DISC_I,
  // Reply bytes.
  output logic      [7:0]            TX_DATA_O,
  output logic                       TX_VALID_O,
  input  wire logic                  TX_READY_I
);

  mrn_state_e  st_q;
  mrn_state_e  st_d;
  logic [3:0]  cnt_q;
  logic [7:0]  buf_q [0:5];
  logic [7:0]  fc_q;
  logic [15:0] off_q;
  logic [15:0] qty_q;
  logic [9:0]  bc_q;
  logic [9:0]  len_q;
  logic [9:0]  t_q;
  logic [8:0]  idx_q;
  logic [7:0]  tx_q;
  logic        vld_q;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [7:0]  pick;

  // Request fields, sent high byte first.
  wire [7:0]  req_addr  = buf_q[0];
  wire [7:0]  req_fc    = buf_q[1];
  wire [15:0] req_start = {buf_q[2], buf_q[3]};
  wire [15:0] req_qty   = {buf_q[4], buf_q[5]};

  // Address filter; an unset or out-of-range address answers nobody.
  wire addr_legal = (SLAVE_ADDR_I >= ADDR_MIN) && (SLAVE_ADDR_I <= ADDR_MAX);
  wire addr_ok    = addr_legal && (req_addr == SLAVE_ADDR_I);

  // Frame integrity: fixed length and zero CRC residue.
  wire len_ok = (cnt_q == REQ_LEN);
  wire crc_ok = (rx_crc == CRC_GOOD);

  // Input register window, relative to the map base.
  wire [15:0] ireg_off = req_start - IREG_BASE;
  wire ireg_ok = (req_start >= IREG_BASE)
               && range_ok(ireg_off, req_qty, 17'(IREG_TOTAL));

  // Bit windows; the map covers all nodes from address zero.
  wire coil_ok = range_ok(req_start, req_qty, 17'(COIL_TOTAL));
  wire disc_ok = range_ok(req_start, req_qty, 17'(DISC_TOTAL));

  // Function decode and quantity check.
  wire fc_ireg = (req_fc == FC_RD_IREG);
  wire fc_coil = (req_fc == FC_RD_COIL);
  wire fc_disc = (req_fc == FC_RD_DISC);
  wire qty_ok  = (fc_ireg && ireg_ok) || (fc_coil && coil_ok) || (fc_disc && disc_ok);

  // Anything failing here is dropped without a word.
  wire req_ok = len_ok && crc_ok && addr_ok && qty_ok;

  // Byte count: two per register, or the bit formula as printed.
  wire [9:0] word_bc = {req_qty[8:0], 1'b0};
  wire [9:0] bit_bc  = req_qty[12:3] + {7'h00, req_qty[2:0]};
  wire [9:0] new_bc  = fc_ireg ? word_bc : bit_bc;

  // Reply position bookkeeping.
  wire [9:0] d_idx   = t_q - HDR_BYTES;
  wire [9:0] crc_pos = len_q - CRC_BYTES;
  wire       at_lo   = (t_q == crc_pos);
  wire       at_hi   = (t_q == len_q - 10'h001);
  wire       in_body = (t_q >= HDR_BYTES) && (t_q < crc_pos);

  // Bit window for the current data byte.
  wire [9:0] bit_done = {d_idx[6:0], 3'h0};
  wire [9:0] bit_from = off_q[9:0] + bit_done;
  wire [9:0] bit_left = (qty_q[9:0] > bit_done) ? (qty_q[9:0] - bit_done) : 10'h000;

  // Coils sit in the low part of the shared picker vector.
  wire [DISC_TOTAL-1:0] bit_vec = (fc_q == FC_RD_COIL)
                                ? {{(DISC_TOTAL-COIL_TOTAL){1'b0}}, COIL_I}
                                : DISC_I;

  mrn_bitpick #(
    .W       (DISC_TOTAL)
  ) u_pick (
    .vec_i   (bit_vec),
    .first_i (bit_from),
    .left_i  (bit_left),
    .byte_o  (pick)
  );

  // Register words go high byte first; values pass unscaled.
  wire [7:0] word_byte = d_idx[0] ? IREG_DATA_I[7:0] : IREG_DATA_I[15:8];

  // Reply byte selection, check field low byte first.
  wire [7:0] body_byte = (fc_q == FC_RD_IREG) ? word_byte : pick;
  wire [7:0] next_byte = (t_q == 10'h000) ? SLAVE_ADDR_I
                       : (t_q == 10'h001) ? fc_q
                       : (t_q == 10'h002) ? bc_q[7:0]
                       : at_lo            ? tx_crc[7:0]
                       : at_hi            ? tx_crc[15:8]
                       : in_body          ? body_byte
                       : 8'h00;

  // Handshake events.
  wire rx_take = (st_q == ST_RX) && RX_VALID_I;
  wire tx_done = (st_q == ST_HOLD) && TX_READY_I;
  wire tx_last = tx_done && at_hi;

  // Both check engines restart when a request is judged.
  mrn_crc16 u_rx_crc (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .clr_i   (st_q == ST_CHK),
    .en_i    (rx_take),
    .byte_i  (RX_DATA_I),
    .crc_o   (rx_crc)
  );

  // The reply check covers every byte before the check field.
  mrn_crc16 u_tx_crc (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .clr_i   (st_q == ST_CHK),
    .en_i    (tx_done && (t_q < crc_pos)),
    .byte_i  (tx_q),
    .crc_o   (tx_crc)
  );

  // Next state; bytes arriving while a reply runs are not heard.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RX:   st_d = RX_END_I ? ST_CHK : ST_RX;
      ST_CHK:  st_d = req_ok ? ST_PREP : ST_RX;
      ST_PREP: st_d = ST_LOAD;
      ST_LOAD: st_d = ST_HOLD;
      ST_HOLD: begin
        if (tx_last) begin
          st_d = ST_RX;
        end else if (tx_done) begin
          st_d = ST_PREP;
        end
      end
      default: st_d = ST_RX;
    endcase
  end

  // State register.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q <= ST_RX;
    end else begin
      st_q <= st_d;
    end
  end

  // Receive side: keep the six header bytes, count the whole frame.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_q <= 4'h0;
      for (int i = 0; i < 6; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (st_q == ST_CHK) begin
      cnt_q <= 4'h0;
    end else if (rx_take) begin
      if (cnt_q < REQ_KEEP) begin
        buf_q[cnt_q[2:0]] <= RX_DATA_I;
      end
      if (cnt_q != 4'hF) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Accepted request is frozen for the whole reply.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fc_q  <= 8'h00;
      off_q <= 16'h0000;
      qty_q <= 16'h0000;
      bc_q  <= 10'h000;
      len_q <= 10'h000;
    end else if ((st_q == ST_CHK) && req_ok) begin
      fc_q  <= req_fc;
      off_q <= fc_ireg ? ireg_off : req_start;
      qty_q <= req_qty;
      bc_q  <= new_bc;
      len_q <= new_bc + HDR_BYTES + CRC_BYTES;
    end
  end

  // Reply position advances on each accepted byte.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      t_q <= 10'h000;
    end else if (st_q == ST_CHK) begin
      t_q <= 10'h000;
    end else if (tx_done) begin
      t_q <= t_q + 10'h001;
    end
  end

  // Register index is set a cycle ahead so the word is stable at load.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      idx_q <= 9'h000;
    end else if ((st_q == ST_PREP) && in_body) begin
      idx_q <= off_q[8:0] + d_idx[9:1];
    end
  end

  // Output byte register with its valid.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_q  <= 8'h00;
      vld_q <= 1'b0;
    end else if (st_q == ST_LOAD) begin
      tx_q  <= next_byte;
      vld_q <= 1'b1;
    end else if (tx_done) begin
      vld_q <= 1'b0;
    end
  end

  assign IREG_IDX_O = idx_q;
  assign TX_DATA_O  = tx_q;
  assign TX_VALID_O = vld_q;

  // Checks on the reply against the judged request.
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_accept;
    (st_q == ST_CHK) && req_ok;
  endsequence

  sequence s_reject;
    (st_q == ST_CHK) && !req_ok;
  endsequence

  sequence s_first_out;
    (st_q == ST_PREP) ##1 (st_q == ST_LOAD) ##1 TX_VALID_O;
  endsequence

  a_reject_silent: assert property (
    s_reject |=> ((st_q == ST_RX) && !TX_VALID_O) [*2]
  ) else $error("Rejected request produced reply activity.");

  a_accept_start: assert property (
    s_accept |=> s_first_out
  ) else $error("Accepted request did not start a reply in three cycles.");

  a_reply_addr: assert property (
    s_accept ##3 1'b1 |-> (TX_DATA_O == SLAVE_ADDR_I)
  ) else $error("Reply does not open with the slave address.");

  a_reply_func: assert property (
    (TX_VALID_O && (t_q == 10'h001)) |-> (TX_DATA_O == fc_q)
  ) else $error("Second reply byte is not the function code.");

  a_word_count: assert property (
    (TX_VALID_O && (t_q == 10'h002) && (fc_q == FC_RD_IREG))
      |-> (TX_DATA_O == 8'({qty_q[8:0], 1'b0}))
  ) else $error("Register byte count is not twice the quantity.");

  a_bit_count: assert property (
    (TX_VALID_O && (t_q == 10'h002) && (fc_q != FC_RD_IREG))
      |-> (TX_DATA_O == 8'(qty_q[15:3] + {13'h0000, qty_q[2:0]}))
  ) else $error("Bit byte count does not follow N/8 + N%8.");

  a_crc_order: assert property (
    (TX_VALID_O && at_lo) |-> (TX_DATA_O == tx_crc[7:0])
  ) else $error("Check field low byte not sent first.");

  a_ireg_limit: assert property (
    (s_accept ##0 (req_fc == FC_RD_IREG)) |-> ({1'b0, ireg_off} + {1'b0, req_qty} <= 17'h0015E)
  ) else $error("Register read past 350 accepted.");

  a_coil_limit: assert property (
    (s_accept ##0 (req_fc == FC_RD_COIL)) |-> (req_qty <= 16'h0064)
  ) else $error("Coil read above 100 accepted.");

  a_disc_limit: assert property (
    (s_accept ##0 (req_fc == FC_RD_DISC)) |-> (req_qty <= 16'h00C8)
  ) else $error("Discrete read above 200 accepted.");

  a_byte_hold: assert property (
    (TX_VALID_O && !TX_READY_I) |=> TX_VALID_O && $stable(TX_DATA_O)
  ) else $error("Reply byte changed while stalled.");

  // Frames that fail a check are dropped at once and the listener is back.
  a_len_drop: assert property (
    ((st_q == ST_CHK) && !len_ok) |=> (st_q == ST_RX)
  ) else $error("Frame of wrong length was not dropped.");

  a_crc_drop: assert property (
    ((st_q == ST_CHK) && !crc_ok) |=> (st_q == ST_RX)
  ) else $error("Frame with a bad check field was not dropped.");

  a_addr_drop: assert property (
    ((st_q == ST_CHK) && !addr_ok) |=> (st_q == ST_RX)
  ) else $error("Frame for another address was not dropped.");

  a_func_drop: assert property (
    ((st_q == ST_CHK) && !(fc_ireg || fc_coil || fc_disc)) |=> (st_q == ST_RX)
  ) else $error("Frame with an unserved function was not dropped.");

  // Reply pacing and tail; a slow sink must never break the byte order.
  a_byte_pace: assert property (
    (tx_done && !at_hi) |=> s_first_out
  ) else $error("Next reply byte did not follow in three cycles.");

  a_crc_high: assert property (
    (TX_VALID_O && at_hi) |-> (TX_DATA_O == tx_crc[15:8])
  ) else $error("Check field high byte not sent last.");

  a_reply_end: assert property (
    tx_last |=> ((st_q == ST_RX) && !TX_VALID_O)
  ) else $error("Responder did not return to listening after the reply.");

  a_bit_pad: assert property (
    (TX_VALID_O && in_body && (fc_q != FC_RD_IREG) && (bit_left == 10'h000))
      |-> (TX_DATA_O == 8'h00)
  ) else $error("Padding byte of a bit reply is not zero.");

  // Register index walks inside the map, from the requested start.
  a_idx_map: assert property (
    (TX_VALID_O && in_body && (fc_q == FC_RD_IREG)) |-> (IREG_IDX_O < 9'(IREG_TOTAL))
  ) else $error("Register index left the node map.");

  a_start_word: assert property (
    (TX_VALID_O && (t_q == HDR_BYTES) && (fc_q == FC_RD_IREG)) |-> (IREG_IDX_O == off_q[8:0])
  ) else $error("First register word is not the requested start.");

endmodule

// ===== hw/mrn_pkg.sv
// Behaviour
// - Act only on frames whose first byte equals our address, legal range 1 to 247.
// - Input registers start at 40000; node n owns seven from (n-1)*7+40000.
// - An input register read beyond 350 registers is invalid.
// - At most 50 wireless nodes are mapped.
// - Every frame ends with a CRC, low byte first; receiver verifies it.
// - Input register reply byte count is twice the quantity, two bytes each.
// - Reply opens with the request's slave address and function code.
// - Temperature, humidity in tenths; light, gas, compounds in whole units.
// - A coil read of more than 100 outputs is invalid.
// - Two-output node ID owns two coil addresses starting at (ID-1)*2.
// - Bit reply byte count is N/8 + N%8.
// - Coil bits are packed into bytes, lower addresses first.
// - Function 0x02 reads discrete inputs of the four-input nodes.
// - A discrete input read of more than 200 inputs is invalid.
// - Four-input node ID owns four input addresses starting at (ID-1)*4.
// - Discrete inputs packed eight to a byte, lowest addresses first.
package mrn_pkg;

  // Function codes served.
  localparam logic [7:0]  FC_RD_COIL = 8'h01;
  localparam logic [7:0]  FC_RD_DISC = 8'h02;
  localparam logic [7:0]  FC_RD_IREG = 8'h04;

  // Legal slave address range.
  localparam logic [7:0]  ADDR_MIN   = 8'h01;
  localparam logic [7:0]  ADDR_MAX   = 8'hF7;

  // Node map.
  localparam logic [15:0] IREG_BASE  = 16'h9C40;
  localparam int          NODE_MAX   = 50;
  localparam int          IREG_NODE  = 7;
  localparam int          COIL_NODE  = 2;
  localparam int          DISC_NODE  = 4;
  localparam int          IREG_TOTAL = NODE_MAX * IREG_NODE;
  localparam int          COIL_TOTAL = NODE_MAX * COIL_NODE;
  localparam int          DISC_TOTAL = NODE_MAX * DISC_NODE;

  // Frame layout.
  localparam logic [3:0]  REQ_LEN    = 4'h8;
  localparam logic [3:0]  REQ_KEEP   = 4'h6;
  localparam logic [9:0]  HDR_BYTES  = 10'h003;
  localparam logic [9:0]  CRC_BYTES  = 10'h002;

  // Check field.
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'hA001;
  localparam logic [15:0] CRC_GOOD   = 16'h0000;

  // Responder states, Gray from ST_RX to ST_HOLD; the steps back from ST_HOLD to ST_PREP and ST_RX change two bits.
  typedef enum logic [2:0] {
    ST_RX   = 3'b000,
    ST_CHK  = 3'b001,
    ST_PREP = 3'b011,
    ST_LOAD = 3'b010,
    ST_HOLD = 3'b110
  } mrn_state_e;

  // One byte of the reflected CRC-16.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Quantity nonzero and the window fits below the limit.
  function automatic logic range_ok(input logic [15:0] s, input logic [15:0] q,
                                    input logic [16:0] lim);
    return (q != 16'h0000) && ({1'b0, q} <= lim) && (({1'b0, s} + {1'b0, q}) <= lim);
  endfunction

endpackage

// ===== hw/mrn_crc16.sv
`timescale 1ns/10ps
// Running CRC-16 over a byte stream, cleared per frame.
module mrn_crc16 import mrn_pkg::*; (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Byte stream.
  input  wire logic        clr_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  byte_i,
  // Result.
  output logic      [15:0] crc_o
);

  // Clear wins over a byte so a new frame always starts clean.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_o <= CRC_INIT;
    end else if (clr_i) begin
      crc_o <= CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_step(crc_o, byte_i);
    end
  end

endmodule

// ===== hw/mrn_bitpick.sv
`timescale 1ns/10ps
// Picks eight bits of a status vector into one reply byte.
module mrn_bitpick #(
  parameter int W = 200
) (
  input  wire logic [W-1:0] vec_i,
  input  wire logic [9:0]   first_i,
  input  wire logic [9:0]   left_i,
  output logic      [7:0]   byte_o
);

  // Bit k holds address first+k; bits past the count or the map read zero.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      byte_o[k] = 1'b0;
      if ((10'(k) < left_i) && ((32'(first_i) + k) < W)) begin
        byte_o[k] = vec_i[32'(first_i) + k];
      end
    end
  end

endmodule

// ===== tb/mrn_master.sv
`timescale 1ns/10ps
// Behavioural master station that sends requests and collects reply bytes.
module mrn_master (
  // Clock.
  input  wire logic       clk_i,
  // Request side.
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_end_o,
  // Reply side.
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;
  logic [1:0] stall_cnt = 2'h0;

  // Reflected CRC-16 of one byte, kept apart from the design's own helper.
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // Idle levels from time zero.
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
  end

  // Sends nb bytes of a request, then the frame gap pulse.
  task automatic send(input logic [7:0] adr, input logic [7:0] fc, input logic [15:0] st,
                      input logic [15:0] qt, input logic [15:0] bad, input int nb);
    logic [7:0]  b[8];
    logic [15:0] c;
    b = '{adr, fc, st[15:8], st[7:0], qt[15:8], qt[7:0], 8'h00, 8'h00};
    c = 16'hFFFF;
    for (int i = 0; i < 6; i++) begin
      c = crc_upd(c, b[i]);
    end
    c = c ^ bad;
    b[6] = c[7:0];
    b[7] = c[15:8];
    for (int i = 0; i < nb; i++) begin
      @(negedge clk_i);
      rx_data_o = b[i];
      rx_valid_o = 1'b1;
    end
    @(negedge clk_i);
    // The released data line shows the inverse so a stale byte cannot pass.
    rx_data_o = ~rx_data_o;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b1;
    @(negedge clk_i);
    rx_end_o = 1'b0;
  endtask

  // Every accepted reply byte is kept for the bench to judge.
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
    end
  end

  // Slow mode accepts in one cycle of four, stretching every handshake.
  always @(negedge clk_i) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready_o <= !slow || (stall_cnt == 2'h3);
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the request responder.
module tb_top import mrn_pkg::*;;
  typedef logic [7:0] mrn_bq_t[$];
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  logic [7:0]            sa;
  logic [7:0]            rx_data;
  logic                  rx_valid;
  logic                  rx_end;
  logic                  tx_ready;
  logic [8:0]            ireg_idx;
  logic [7:0]            tx_data;
  logic                  tx_valid;
  logic [15:0]           ireg_mem[350];
  logic [COIL_TOTAL-1:0] coil;
  logic [DISC_TOTAL-1:0] disc;
  logic [31:0]           rnd = 32'hACE0;
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    n_tests = 0;
  // An index past the map reads unknown and so shows up as a mismatch.
  wire  [15:0]           ireg_data = ireg_mem[ireg_idx];

  // Free-running clock.
  always #4 clk = ~clk;

  mrn_responder u_dut (
    .REF_CLK_I(clk), .NRST_I(nrst), .SLAVE_ADDR_I(sa), .RX_DATA_I(rx_data),
    .RX_VALID_I(rx_valid), .RX_END_I(rx_end), .IREG_IDX_O(ireg_idx),
    .IREG_DATA_I(ireg_data), .COIL_I(coil), .DISC_I(disc), .TX_DATA_O(tx_data),
    .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready)
  );

  mrn_master u_mst (
    .clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_end_o(rx_end),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready)
  );

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one reply byte.
  task automatic cmp_byte(input int i, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH reply byte %0d expected %h seen %h", i, e, g);
    end
  endtask

  // Compares the number of reply bytes.
  task automatic cmp_len(input int e, input int g);
    checks_done++;
    if (g != e) begin
      n_errors++;
      $display("MISMATCH reply length expected %0d seen %0d", e, g);
    end
  endtask

  // Next state of the pseudo-random shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // New random node values; called only while the responder is idle.
  task automatic refill();
    for (int i = 0; i < 350; i++) begin
      rnd = lfsr_next(rnd);
      ireg_mem[i] = rnd[15:0];
      if (i < DISC_TOTAL) disc[i] = rnd[20];
      if (i < COIL_TOTAL) coil[i] = rnd[9];
    end
  endtask

  // Whole expected reply, check field included.
  function automatic mrn_bq_t expect_reply(input logic [7:0] adr, input logic [7:0] fc,
                                           input int st, input int qt);
    mrn_bq_t     r;
    logic [15:0] c;
    logic [7:0]  v;
    int          n;
    r.push_back(adr);
    r.push_back(fc);
    if (fc == FC_RD_IREG) begin
      n = 2 * qt;
      r.push_back(n[7:0]);
      for (int j = 0; j < qt; j++) begin
        r.push_back(ireg_mem[st - 40000 + j][15:8]);
        r.push_back(ireg_mem[st - 40000 + j][7:0]);
      end
    end else begin
      n = qt / 8 + qt % 8;
      r.push_back(n[7:0]);
      for (int j = 0; j < n; j++) begin
        v = 8'h00;
        for (int k = 0; k < 8; k++) begin
          if (8 * j + k < qt) begin
            v[k] = (fc == FC_RD_COIL) ? coil[st + 8 * j + k]
                                      : disc[st + 8 * j + k];
          end
        end
        r.push_back(v);
      end
    end
    c = 16'hFFFF;
    foreach (r[i]) c = u_mst.crc_upd(c, r[i]);
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    return r;
  endfunction

  // One request and its reply, or its silence when ok is low.
  task automatic run(input logic [7:0] adr, input logic [7:0] fc, input logic [15:0] st,
                     input logic [15:0] qt, input logic [15:0] bad, input int nb,
                     input logic ok);
    mrn_bq_t e;
    if (ok) e = expect_reply(adr, fc, st, qt);
    u_mst.got_q.delete();
    u_mst.send(adr, fc, st, qt, bad, nb);
    for (int i = 0; i < 9000 && u_mst.got_q.size() < e.size(); i++) @(posedge clk);
    repeat (40) @(posedge clk);
    cmp_len(e.size(), u_mst.got_q.size());
    for (int i = 0; i < e.size() && i < u_mst.got_q.size(); i++) begin
      cmp_byte(i, e[i], u_mst.got_q[i]);
    end
    n_tests++;
    $display("test %0d done, %0d reply bytes", n_tests, u_mst.got_q.size());
  endtask

  // Corner cases first, then random reads with the sink sometimes stalling.
  initial begin
    logic [7:0] fc;
    int         lim;
    int         q;
    refill();
    sa = 8'h01 + 8'(rnd % 247);
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    run(sa, FC_RD_IREG, IREG_BASE, 16'h0007, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_IREG, 16'h9D97, 16'h0007, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_IREG, IREG_BASE, 16'h015E, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_IREG, IREG_BASE, 16'h015F, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_IREG, 16'h9C3F, 16'h0001, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_COIL, 16'h0000, 16'h0064, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_COIL, 16'h0000, 16'h0065, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_COIL, 16'h0002, 16'h0002, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_DISC, 16'h0000, 16'h00C8, 16'h0000, 8, 1'b1);
    run(sa, FC_RD_DISC, 16'h0000, 16'h00C9, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_DISC, 16'h0004, 16'h0004, 16'h0000, 8, 1'b1);
    run(sa ^ 8'h01, FC_RD_IREG, IREG_BASE, 16'h0007, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_IREG, IREG_BASE, 16'h0007, 16'h0100, 8, 1'b0);
    run(sa, FC_RD_DISC, 16'h0000, 16'h0000, 16'h0000, 8, 1'b0);
    run(sa, 8'h03, 16'h0000, 16'h0001, 16'h0000, 8, 1'b0);
    run(sa, FC_RD_COIL, 16'h0000, 16'h0008, 16'h0000, 7, 1'b0);
    for (int t = 0; t < 16; t++) begin
      @(negedge clk);
      refill();
      u_mst.slow = rnd[4];
      fc = (rnd[1:0] == 2'h0) ? FC_RD_IREG : (rnd[0] ? FC_RD_COIL : FC_RD_DISC);
      lim = (fc == FC_RD_IREG) ? IREG_TOTAL : ((fc == FC_RD_COIL) ? COIL_TOTAL : DISC_TOTAL);
      q = 1 + rnd[15:8] % lim;
      run(sa, fc, 16'(rnd[31:16] % (lim - q + 1) + ((fc == FC_RD_IREG) ? 40000 : 0)),
          16'(q), 16'h0000, 8, 1'b1);
    end
    conclude();
  end

  // Watchdog well beyond the longest expected run.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule
